// [rtl/swl_dev.sv]
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Only pull the line low or release.
// - Device answers only host-started transactions.
// - Bytes travel least significant bit first.
// - Command: code bits 0-6, direction bit 7.
// - Direction picks receive or send data byte.
// - Host opens with break then recovery.
// - Host sends command as eight host slots.
// - Line returns high for rest of slot.
// - Host write data uses eight host slots.
// - Device read data uses eight device slots.
// - No auto-increment; one byte per transaction.
// - Mode entry by configuration or immediate subcommand.
// - Direct switch picks event pin; swap follows configuration.
// - Link runs on event or dedicated pin.
module swl_dev (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Configuration and subcommands
  input wire logic cfg_type_i,
  input wire logic cfg_pin_i,
  input wire logic switch_cmd_i,
  input wire logic swap_cmd_i,
  // Register side
  input wire logic [7:0] rd_data_i,
  output logic wr_o,
  output logic rd_o,
  output logic [6:0] code_o,
  output logic [7:0] wdata_o,
  output logic active_o,
  output logic pin_sel_o,
  // Link
  swl_if.dev link
);
  typedef enum logic [4:0] {
    D_IDLE = 5'h01,
    D_CMD = 5'h02,
    D_WR = 5'h04,
    D_TURN = 5'h08,
    D_RD = 5'h10
  } swl_dst_t;

  swl_dst_t st_q;
  logic act_q, psel_q;
  logic s1_q, s2_q, prev_q;
  logic [31:0] lowc_q, cnt_q;
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic [6:0] code_q;
  logic [7:0] wdata_q, rdat_q;
  logic wr_q, rd_q, tx_start_q;
  logic tx_busy, tx_done, tx_pull;
  logic evt_oe_q, ded_oe_q;

  swl_slot_tx #(
    .SLOT_CYC(swl_pkg::DEV_SLOT_CYC),
    .ZERO_CYC(swl_pkg::DEV_ZERO_CYC),
    .ONE_CYC(swl_pkg::DEV_ONE_CYC)
  ) u_tx (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .start_i(tx_start_q),
    .byte_i(rdat_q),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .pull_o(tx_pull)
  );

  wire line_raw = psel_q ? link.ded_line : link.evt_line;
  wire rise = s2_q && !prev_q;
  wire is_break = rise && (lowc_q >= 32'(swl_pkg::BREAK_DETECT_CYC));
  wire rbit = (lowc_q < 32'(swl_pkg::SAMPLE_THRESH_CYC));
  wire byte_last = (bits_q == swl_pkg::BITS_PER_BYTE - 4'h1);
  wire [7:0] sh_next = {rbit, sh_q[7:1]};
  wire dir_write = sh_next[swl_pkg::DIR_BIT];
  // The reply waits out the rest of the host slot, then the turnaround gap.
  wire turn_end = (cnt_q == 32'(swl_pkg::HOST_SLOT_CYC + swl_pkg::TURNAROUND_CYC));
  wire cfg_single = (cfg_type_i == swl_pkg::IF_SINGLE_WIRE);
  wire pull_now = tx_busy && tx_pull;

  // Only the selected pin is ever pulled, so the other pin stays released.
  function automatic logic pulls_pin(input logic pull, input logic sel, input logic pin);
    return pull && (sel == pin);
  endfunction

  // Mode and pin follow configuration while inactive; subcommands act on the next edge.
  // While active, only a swap or switch subcommand changes mode or pin, and it acts even mid-frame.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      act_q <= 1'b0;
      psel_q <= swl_pkg::PIN_EVENT;
    end else if (switch_cmd_i) begin
      act_q <= 1'b1;
      psel_q <= swl_pkg::PIN_EVENT;
    end else if (swap_cmd_i) begin
      act_q <= cfg_single;
      psel_q <= cfg_pin_i;
    end else if (!act_q && cfg_single) begin
      act_q <= 1'b1;
      psel_q <= cfg_pin_i;
    end
  end

  // The low counter holds the width of each pulse when the line rises again.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
      lowc_q <= '0;
    end else begin
      s1_q <= line_raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
      lowc_q <= s2_q ? 32'h0 : lowc_q + 32'h1;
    end
  end

  // A break restarts reception unless the device is sending, so a lost bit never wedges the link.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= D_IDLE;
      sh_q <= 8'h00;
      bits_q <= 4'h0;
      code_q <= 7'h00;
      wdata_q <= 8'h00;
      rdat_q <= 8'h00;
      cnt_q <= '0;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      tx_start_q <= 1'b0;
      cnt_q <= cnt_q + 32'h1;
      if (!act_q) begin
        st_q <= D_IDLE;
      end else if (is_break && !tx_busy) begin
        st_q <= D_CMD;
        bits_q <= 4'h0;
      end else begin
        unique case (st_q)
          D_IDLE: ;
          D_CMD: if (rise) begin
            sh_q <= sh_next;
            bits_q <= bits_q + 4'h1;
            if (byte_last) begin
              bits_q <= 4'h0;
              code_q <= sh_next[swl_pkg::CODE_W-1:0];
              // Count from the fall of the last command bit so the host slot ends first.
              cnt_q <= lowc_q;
              if (dir_write) begin
                st_q <= D_WR;
              end else begin
                st_q <= D_TURN;
                rd_q <= 1'b1;
              end
            end
          end
          D_WR: if (rise) begin
            sh_q <= sh_next;
            bits_q <= bits_q + 4'h1;
            if (byte_last) begin
              wdata_q <= sh_next;
              wr_q <= 1'b1;
              st_q <= D_IDLE;
            end
          end
          D_TURN: if (turn_end) begin
            // Read data is taken once, as late as possible, to give the source time.
            rdat_q <= rd_data_i;
            tx_start_q <= 1'b1;
            st_q <= D_RD;
          end
          D_RD: if (tx_done) begin
            st_q <= D_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_oe_q <= 1'b0;
      ded_oe_q <= 1'b0;
    end else begin
      evt_oe_q <= pulls_pin(pull_now, psel_q, swl_pkg::PIN_EVENT);
      ded_oe_q <= pulls_pin(pull_now, psel_q, swl_pkg::PIN_DEDICATED);
    end
  end

  assign link.dev_evt_oe = evt_oe_q;
  assign link.dev_ded_oe = ded_oe_q;
  assign wr_o = wr_q;
  assign rd_o = rd_q;
  assign code_o = code_q;
  assign wdata_o = wdata_q;
  assign active_o = act_q;
  assign pin_sel_o = psel_q;
endmodule
`default_nettype wire

// [rtl/swl_host.sv]
`timescale 1ns/100ps
`default_nettype none
module swl_host (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Request
  input wire logic req_i,
  input wire logic write_i,
  input wire logic [6:0] code_i,
  input wire logic [7:0] wdata_i,
  input wire logic use_dedicated_i,
  // Answer
  output logic busy_o,
  output logic done_o,
  output logic timeout_o,
  output logic [7:0] rdata_o,
  // Link
  swl_if.host link
);
  typedef enum logic [5:0] {
    H_IDLE = 6'h01, H_BRK = 6'h02, H_REC = 6'h04, H_CMD = 6'h08, H_WR = 6'h10, H_RD = 6'h20
  } swl_hst_t;
  localparam int TOUT_CYC = swl_pkg::DEV_SLOT_CYC * 12;

  swl_hst_t st_q;
  logic [31:0] cnt_q;
  logic [7:0] data_q;
  logic [7:0] rsh_q;
  logic [3:0] rbits_q;
  logic lsel_q, busy_q, done_q, tout_q, tx_start_q;
  logic s1_q, s2_q, prev_q;
  logic [31:0] lowc_q;
  logic tx_busy, tx_done, tx_pull;

  swl_slot_tx #(
    .SLOT_CYC(swl_pkg::HOST_SLOT_CYC),
    .ZERO_CYC(swl_pkg::HOST_ZERO_CYC),
    .ONE_CYC(swl_pkg::HOST_ONE_CYC)
  ) u_tx (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .start_i(tx_start_q),
    .byte_i(data_q),
    .busy_o(tx_busy),
    .done_o(tx_done),
    .pull_o(tx_pull)
  );

  wire line_raw = lsel_q ? link.ded_line : link.evt_line;
  wire rise = s2_q && !prev_q;
  wire rbit = (lowc_q < 32'(swl_pkg::SAMPLE_THRESH_CYC));

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      prev_q <= 1'b1;
      lowc_q <= '0;
    end else begin
      s1_q <= line_raw;
      s2_q <= s1_q;
      prev_q <= s2_q;
      lowc_q <= s2_q ? 32'h0 : lowc_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_q <= H_IDLE;
      cnt_q <= '0;
      data_q <= 8'h00;
      rsh_q <= 8'h00;
      rbits_q <= 4'h0;
      lsel_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      tout_q <= 1'b0;
      tx_start_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      tx_start_q <= 1'b0;
      cnt_q <= cnt_q + 32'h1;
      unique case (st_q)
        H_IDLE: if (req_i) begin
          // Each byte is its own full transaction with break and command.
          st_q <= H_BRK;
          cnt_q <= '0;
          lsel_q <= use_dedicated_i;
          busy_q <= 1'b1;
          tout_q <= 1'b0;
          data_q <= {write_i, code_i};
        end
        H_BRK: if (cnt_q == 32'(swl_pkg::BREAK_CYC - 1)) begin
          st_q <= H_REC;
          cnt_q <= '0;
        end
        H_REC: if (cnt_q == 32'(swl_pkg::BREAK_RECOVERY_CYC - 1)) begin
          st_q <= H_CMD;
          tx_start_q <= 1'b1;
        end
        H_CMD: if (tx_done) begin
          cnt_q <= '0;
          rbits_q <= 4'h0;
          if (data_q[swl_pkg::DIR_BIT]) begin
            st_q <= H_WR;
            data_q <= wdata_i;
            tx_start_q <= 1'b1;
          end else begin
            st_q <= H_RD;
          end
        end
        H_WR: if (tx_done) begin
          st_q <= H_IDLE;
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        H_RD: begin
          if (rise) begin
            rsh_q <= {rbit, rsh_q[7:1]};
            rbits_q <= rbits_q + 4'h1;
            cnt_q <= '0;
          end
          if (rise && rbits_q == swl_pkg::BITS_PER_BYTE - 4'h1) begin
            st_q <= H_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end else if (cnt_q == 32'(TOUT_CYC)) begin
            st_q <= H_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b1;
            tout_q <= 1'b1;
          end
        end
      endcase
    end
  end

  logic oe_q;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (st_q == H_BRK) || (tx_busy && tx_pull);
    end
  end

  assign link.host_oe = oe_q;
  assign busy_o = busy_q;
  assign done_o = done_q;
  assign timeout_o = tout_q;
  assign rdata_o = rsh_q;
endmodule
`default_nettype wire

// [rtl/swl_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface swl_if;
  // Open-drain line: whoever enables pulls it low, otherwise the pull-up wins.
  logic host_oe;
  logic dev_evt_oe;
  logic dev_ded_oe;
  logic evt_line;
  logic ded_line;

  modport host (output host_oe, input evt_line, input ded_line);
  modport dev (output dev_evt_oe, output dev_ded_oe, input evt_line, input ded_line);
endinterface
`default_nettype wire

// [rtl/swl_pkg.sv]
package swl_pkg;
  // Slot timing in nanoseconds; plain defaults, kept short so that a run stays brief.
  localparam int CLK_PERIOD_NS = 10;
  localparam int BREAK_NS = 9500;
  localparam int BREAK_RECOVERY_NS = 2000;
  localparam int HOST_SLOT_NS = 9500;
  localparam int HOST_ZERO_NS = 5000;
  localparam int HOST_ONE_NS = 1500;
  localparam int DEV_SLOT_NS = 9500;
  localparam int DEV_ZERO_NS = 5000;
  localparam int DEV_ONE_NS = 1500;
  localparam int SAMPLE_THRESH_NS = 3250;
  localparam int BREAK_DETECT_NS = 7500;
  localparam int TURNAROUND_NS = 2500;

  // Cycle counts: least times round up, longest times round down.
  localparam int BREAK_CYC = (BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BREAK_RECOVERY_CYC = (BREAK_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_SLOT_CYC = (HOST_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOST_ZERO_CYC = HOST_ZERO_NS / CLK_PERIOD_NS;
  localparam int HOST_ONE_CYC = HOST_ONE_NS / CLK_PERIOD_NS;
  localparam int DEV_SLOT_CYC = (DEV_SLOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEV_ZERO_CYC = DEV_ZERO_NS / CLK_PERIOD_NS;
  localparam int DEV_ONE_CYC = DEV_ONE_NS / CLK_PERIOD_NS;
  localparam int SAMPLE_THRESH_CYC = SAMPLE_THRESH_NS / CLK_PERIOD_NS;
  localparam int BREAK_DETECT_CYC = BREAK_DETECT_NS / CLK_PERIOD_NS;
  localparam int TURNAROUND_CYC = (TURNAROUND_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command byte layout.
  localparam int CODE_W = 7;
  localparam int BYTE_W = 8;
  localparam int DIR_BIT = 7;
  localparam int BIT_CNT_W = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Interface type and pin selection.
  localparam logic IF_OTHER = 1'h0;
  localparam logic IF_SINGLE_WIRE = 1'h1;
  localparam logic PIN_EVENT = 1'h0;
  localparam logic PIN_DEDICATED = 1'h1;
endpackage

// [rtl/swl_slot_tx.sv]
`timescale 1ns/100ps
`default_nettype none
module swl_slot_tx #(
  parameter int SLOT_CYC = 19000,
  parameter int ZERO_CYC = 10000,
  parameter int ONE_CYC = 3000
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Byte to send
  input wire logic start_i,
  input wire logic [7:0] byte_i,
  // Status and line
  output logic busy_o,
  output logic done_o,
  output logic pull_o
);
  localparam int CW = $clog2(SLOT_CYC + 1);
  localparam logic [CW-1:0] SLOT_LAST = CW'(SLOT_CYC - 1);
  localparam logic [CW-1:0] ZERO_W = CW'(ZERO_CYC);
  localparam logic [CW-1:0] ONE_W = CW'(ONE_CYC);

  logic [CW-1:0] cnt_q;
  logic [7:0] sh_q;
  logic [3:0] bits_q;
  logic busy_q;
  logic done_q;
  logic pull_q;

  wire slot_end = (cnt_q == SLOT_LAST);
  wire [CW-1:0] width = sh_q[0] ? ONE_W : ZERO_W;
  wire last_bit = (bits_q == swl_pkg::BITS_PER_BYTE - 4'h1);

  // Each slot pulls low for the bit width, then releases to the end of the slot.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      sh_q <= 8'h00;
      bits_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      pull_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        if (start_i) begin
          busy_q <= 1'b1;
          sh_q <= byte_i;
          cnt_q <= '0;
          bits_q <= 4'h0;
          pull_q <= 1'b1;
        end
      end else if (slot_end) begin
        cnt_q <= '0;
        sh_q <= sh_q >> 1;
        bits_q <= bits_q + 4'h1;
        pull_q <= !last_bit;
        busy_q <= !last_bit;
        done_q <= last_bit;
      end else begin
        cnt_q <= cnt_q + 1'b1;
        pull_q <= (cnt_q + 1'b1) < width;
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign pull_o = pull_q;
endmodule
`default_nettype wire

// [testbench/swl_link_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module swl_link_sva (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // Link enables and lines
  input wire logic host_oe,
  input wire logic dev_evt_oe,
  input wire logic dev_ded_oe,
  input wire logic evt_line,
  input wire logic ded_line
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  logic [19:0] h_low_q;
  logic [19:0] h_slot_q;
  logic [19:0] d_low_q;
  logic [19:0] d_slot_q;
  logic brk_q;
  wire logic dev_oe;
  assign dev_oe = dev_evt_oe | dev_ded_oe;

  function automatic logic [19:0] inc(input logic [19:0] v);
    return (&v) ? v : v + 20'h1;
  endfunction

  // Slot counters start saturated so the first pulse after reset never looks like a short slot.
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      h_low_q <= '0;
      d_low_q <= '0;
      h_slot_q <= '1;
      d_slot_q <= '1;
      brk_q <= 1'b0;
    end else begin
      h_low_q <= host_oe ? inc(h_low_q) : '0;
      d_low_q <= dev_oe ? inc(d_low_q) : '0;
      h_slot_q <= (host_oe && h_low_q == '0) ? 20'h1 : inc(h_slot_q);
      d_slot_q <= (dev_oe && d_low_q == '0) ? 20'h1 : inc(d_slot_q);
      brk_q <= brk_q | (h_low_q >= swl_pkg::BREAK_DETECT_CYC);
    end
  end

  a_dev_one_pin: assert property (!(dev_evt_oe && dev_ded_oe))
    else $error("device pulls both pins");
  a_no_collide: assert property (!(host_oe && dev_oe))
    else $error("device pulls while host pulls");
  a_dev_after_brk: assert property ($rose(dev_oe) |-> brk_q)
    else $error("device pulse without host break");
  a_host_width: assert property ($fell(host_oe) |-> h_low_q inside
    {swl_pkg::HOST_ONE_CYC, swl_pkg::HOST_ZERO_CYC, swl_pkg::BREAK_CYC})
    else $error("host pulse width wrong");
  a_dev_width: assert property ($fell(dev_oe) |-> d_low_q inside
    {swl_pkg::DEV_ONE_CYC, swl_pkg::DEV_ZERO_CYC})
    else $error("device pulse width wrong");
  a_host_slot: assert property ((host_oe && h_low_q == '0) |->
    h_slot_q >= swl_pkg::HOST_SLOT_CYC)
    else $error("host slot too short");
  a_dev_slot: assert property ((dev_oe && d_low_q == '0) |->
    d_slot_q >= swl_pkg::DEV_SLOT_CYC)
    else $error("device slot too short");
  a_reset_idle: assert property ($rose(nrst_i) |-> !host_oe && !dev_oe)
    else $error("line pulled at reset release");

  c_host_break: cover property ($fell(host_oe) && h_low_q == swl_pkg::BREAK_CYC);
  c_dev_evt: cover property ($fell(dev_evt_oe) && evt_line);
  c_dev_ded: cover property ($fell(dev_ded_oe) && ded_line);
endmodule
`default_nettype wire

// [testbench/tb_single_wire_responder_link.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_single_wire_responder_link;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic req = 1'b0;
  logic wr_en = 1'b0;
  logic [6:0] code = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic use_ded = 1'b0;
  logic cfg_type = 1'b0;
  logic cfg_pin = 1'b0;
  logic sw_cmd = 1'b0;
  logic swap_cmd = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic busy, done, tmo, dwr, drd, act, psel;
  logic [7:0] rdata;
  logic [7:0] dwdata;
  logic [6:0] dcode;
  logic [7:0] wr_n = 8'h00;
  logic [7:0] rd_n = 8'h00;
  logic [7:0] nbits = 8'h00;
  logic [15:0] sh = 16'h0000;
  logic wire_l;
  int low_n = 0;
  int compares = 0;
  int miscompares = 0;

  swl_if link();
  // Open drain: any enabled party pulls its pin low, otherwise the pull-up wins.
  assign link.evt_line = !((link.host_oe && !use_ded) || link.dev_evt_oe);
  assign link.ded_line = !((link.host_oe && use_ded) || link.dev_ded_oe);
  assign wire_l = link.evt_line & link.ded_line;

  swl_host u_swl_host (.core_clk_i(core_clk), .nrst_i(nrst), .req_i(req), .write_i(wr_en),
    .code_i(code), .wdata_i(wdata), .use_dedicated_i(use_ded), .busy_o(busy),
    .done_o(done), .timeout_o(tmo), .rdata_o(rdata), .link(link));
  swl_dev u_swl_dev (.core_clk_i(core_clk), .nrst_i(nrst), .cfg_type_i(cfg_type),
    .cfg_pin_i(cfg_pin), .switch_cmd_i(sw_cmd), .swap_cmd_i(swap_cmd), .rd_data_i(rd_data),
    .wr_o(dwr), .rd_o(drd), .code_o(dcode), .wdata_o(dwdata), .active_o(act),
    .pin_sel_o(psel), .link(link));
  swl_link_sva u_swl_link_sva (.core_clk_i(core_clk), .nrst_i(nrst), .host_oe(link.host_oe),
    .dev_evt_oe(link.dev_evt_oe), .dev_ded_oe(link.dev_ded_oe), .evt_line(link.evt_line),
    .ded_line(link.ded_line));

  always #5 core_clk = ~core_clk;

  // Wire decoder: a long low restarts the bit count, short lows are ones, shifted in LSB first.
  always @(posedge core_clk) begin
    if (dwr === 1'b1) wr_n <= wr_n + 8'h01;
    if (drd === 1'b1) rd_n <= rd_n + 8'h01;
    if (!wire_l) begin
      low_n <= low_n + 1;
    end else if (low_n > 0) begin
      if (low_n >= swl_pkg::BREAK_DETECT_CYC) begin
        nbits <= 8'h00;
      end else begin
        sh <= {(low_n < swl_pkg::SAMPLE_THRESH_CYC), sh[15:1]};
        nbits <= nbits + 8'h01;
      end
      low_n <= 0;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [6:0] c, input logic [7:0] d, input logic ded);
    @(negedge core_clk);
    req = 1'b1;
    wr_en = w;
    code = c;
    wdata = d;
    use_ded = ded;
    @(negedge core_clk);
    req = 1'b0;
    check(16'(busy), 16'h0001, "busy during transfer");
    while (done !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    repeat (3) @(negedge core_clk);
    check(16'(busy), 16'h0000, "idle after done");
  endtask

  task automatic pulse_cmd(input logic is_swap);
    @(negedge core_clk);
    if (is_swap) swap_cmd = 1'b1;
    else sw_cmd = 1'b1;
    @(negedge core_clk);
    swap_cmd = 1'b0;
    sw_cmd = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic finish_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Four transactions, one ending in a read timeout, take about 69,000 cycles.
  initial begin
    #950000;
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (5) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    check(16'(act), 16'h0000, "idle mode");
    cfg_type = swl_pkg::IF_SINGLE_WIRE;
    cfg_pin = swl_pkg::PIN_EVENT;
    repeat (3) @(negedge core_clk);
    check(16'(act), 16'h0001, "mode by config");
    check(16'(psel), 16'(swl_pkg::PIN_EVENT), "event pin");
    xfer(1'b1, 7'h55, 8'hA3, 1'b0);
    check(16'(wr_n), 16'h0001, "write strobes");
    check(16'(rd_n), 16'h0000, "no read on write");
    check(16'(dcode), 16'h0055, "write code");
    check(16'(dwdata), 16'h00A3, "write data");
    check(sh, {8'hA3, 1'b1, 7'h55}, "write wire order");
    check(16'(nbits), 16'h0010, "write bit count");
    cfg_pin = swl_pkg::PIN_DEDICATED;
    rd_data = 8'h3C;
    pulse_cmd(1'b1);
    check(16'(psel), 16'(swl_pkg::PIN_DEDICATED), "dedicated pin");
    xfer(1'b0, 7'h2A, 8'h00, 1'b1);
    check(16'(rd_n), 16'h0001, "read strobes");
    check(16'(wr_n), 16'h0001, "no write on read");
    check(16'(dcode), 16'h002A, "read code");
    check(16'(rdata), 16'h003C, "read data");
    check(16'(tmo), 16'h0000, "read answered");
    check(sh, {8'h3C, 1'b0, 7'h2A}, "read wire order");
    check(16'(nbits), 16'h0010, "read bit count");
    pulse_cmd(1'b0);
    check(16'(act), 16'h0001, "switch active");
    check(16'(psel), 16'(swl_pkg::PIN_EVENT), "switch to event pin");
    rd_data = 8'hC5;
    xfer(1'b0, 7'h33, 8'h00, 1'b0);
    check(16'(rdata), 16'h00C5, "event pin read data");
    check(sh, {8'hC5, 1'b0, 7'h33}, "event pin wire order");
    check(16'(rd_n), 16'h0002, "second read strobe");
    cfg_type = swl_pkg::IF_OTHER;
    pulse_cmd(1'b1);
    check(16'(act), 16'h0000, "swap follows config");
    xfer(1'b0, 7'h11, 8'h00, 1'b0);
    check(16'(tmo), 16'h0001, "inactive device silent");
    check(16'(rd_n), 16'h0002, "no read when inactive");
    check(16'(nbits), 16'h0008, "command only on wire");
    finish_test();
  end
endmodule
`default_nettype wire
